// file: rtl/etc_trigger_top.sv
// trigger conditioning top: input sync, encoder divider, event logic, apb registers
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "etc_params.svh"
module etc_trigger_top #(
  parameter logic [31:0] EXPO_RST_CYC = 32'(`ETC_EXPO_CYC),
  parameter logic [31:0] LINE_RST_CYC = 32'(`ETC_LINE_PERIOD_CYC)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [2:0] lineIn,
  input etc_pkg::etc_apb_req_t apbReq,
  output etc_pkg::etc_apb_rsp_t apbRsp,
  output etc_pkg::etc_evt_t evt
);
  import etc_pkg::*;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] lineDly;
    etc_trig_cfg_t trgAcq;
    etc_trig_cfg_t trgFrame;
    etc_trig_cfg_t trgLine;
    logic [1:0] encSrcA;
    logic [1:0] encSrcB;
    logic encHiRes;
    logic encDirUp;
    logic [31:0] encDiv;
    logic [32:0] encAcc;
    logic encPulse;
    logic expoWidth;
    logic [31:0] expoTime;
    logic [31:0] linePeriod;
    logic [31:0] frameLines;
    logic [15:0] frameDelay;
    logic [3:0] swPend;
    logic [31:0] periodCnt;
    logic [31:0] expoCnt;
    logic [15:0] delayCnt;
    logic [31:0] lineCnt;
    etc_frame_st_t frameSt;
    etc_evt_t evt;
    etc_apb_rsp_t rsp;
  } etc_top_st_t;

  etc_top_st_t st_ff;
  etc_top_st_t nxt_st;
  logic decStep;
  logic decDir;
  logic [31:0] decPos;

  // pick one of the three input lines; index 3 reads as low
  function automatic logic pickLine(input logic [2:0] v, input logic [1:0] idx);
    pickLine = (idx == 2'h3) ? 1'b0 : v[idx];
  endfunction

  // trigger edge of the selected source for one event
  function automatic logic trigEdge(input etc_trig_cfg_t cfg, input logic [2:0] rise,
                                    input logic [2:0] fall, input logic enc,
                                    input logic sw);
    case (cfg.src)
      `ETC_SRC_ENC: trigEdge = enc;
      `ETC_SRC_LINE: trigEdge = cfg.fall ? pickLine(fall, cfg.line)
                                         : pickLine(rise, cfg.line);
      `ETC_SRC_SW: trigEdge = sw;
      default: trigEdge = 1'b0;
    endcase
  endfunction

  // encoder phases routed from any input line
  etc_quad_decoder decoder (
    .mclk(mclk),
    .reset(reset),
    .phaseA(pickLine(st_ff.sync2, st_ff.encSrcA)),
    .phaseB(pickLine(st_ff.sync2, st_ff.encSrcB)),
    .hiRes(st_ff.encHiRes),
    .step(decStep),
    .dir(decDir),
    .pos(decPos)
  );

  // next-state logic of the whole block
  always_comb begin
    logic [2:0] rise;
    logic [2:0] fall;
    logic encStep;
    logic [32:0] accSum;
    logic acqEdge;
    logic frameEdge;
    logic lineEdge;
    logic lineReq;
    logic lineAccept;
    logic widthMode;
    logic srcLevel;
    logic startFrame;
    rise = 3'h0;
    fall = 3'h0;
    encStep = 1'b0;
    accSum = 33'h0;
    acqEdge = 1'b0;
    frameEdge = 1'b0;
    lineEdge = 1'b0;
    lineReq = 1'b0;
    lineAccept = 1'b0;
    widthMode = 1'b0;
    srcLevel = 1'b0;
    startFrame = 1'b0;
    nxt_st = st_ff;

    // two-stage sync of the pins, then edge detect on the second stage
    nxt_st.sync1 = lineIn;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.lineDly = st_ff.sync2;
    rise = st_ff.sync2 & ~st_ff.lineDly;
    fall = ~st_ff.sync2 & st_ff.lineDly;

    // direction filter and fractional divider in 16.16 steps
    encStep = decStep && (decDir || !st_ff.encDirUp);
    nxt_st.encPulse = 1'b0;
    if (encStep) begin
      accSum = st_ff.encAcc + `ETC_ENC_ONE;
      if (accSum >= {1'b0, st_ff.encDiv}) begin
        nxt_st.encPulse = 1'b1;
        nxt_st.encAcc = accSum - {1'b0, st_ff.encDiv};
      end else begin
        nxt_st.encAcc = accSum;
      end
    end

    // trigger edges of the three events
    acqEdge = trigEdge(st_ff.trgAcq, rise, fall, st_ff.encPulse, st_ff.swPend[`ETC_SW_ACQ]);
    frameEdge = trigEdge(st_ff.trgFrame, rise, fall, st_ff.encPulse,
                         st_ff.swPend[`ETC_SW_FRAME]);
    lineEdge = trigEdge(st_ff.trgLine, rise, fall, st_ff.encPulse,
                        st_ff.swPend[`ETC_SW_LINE]);
    nxt_st.swPend = 4'h0;
    nxt_st.evt.acqStart = 1'b0;
    nxt_st.evt.frameStart = 1'b0;
    nxt_st.evt.lineStart = 1'b0;

    // acquisition: free when trigger mode off, else armed by its trigger
    if (st_ff.swPend[`ETC_SW_STOP]) begin
      nxt_st.evt.acqActive = 1'b0;
    end
    if (!st_ff.trgAcq.mode) begin
      nxt_st.evt.acqActive = 1'b1;
      nxt_st.evt.acqStart = !st_ff.evt.acqActive;
    end else if (acqEdge && !st_ff.evt.acqActive) begin
      nxt_st.evt.acqActive = 1'b1;
      nxt_st.evt.acqStart = 1'b1;
    end

    // line requests: free-running period or selected trigger source
    if (!st_ff.trgLine.mode && st_ff.evt.acqActive) begin
      if (st_ff.periodCnt + 32'h1 >= st_ff.linePeriod) begin
        nxt_st.periodCnt = 32'h0;
        lineReq = 1'b1;
      end else begin
        nxt_st.periodCnt = st_ff.periodCnt + 32'h1;
      end
    end else begin
      nxt_st.periodCnt = 32'h0;
      lineReq = st_ff.trgLine.mode && lineEdge;
    end
    // a request during exposure is dropped
    lineAccept = lineReq && st_ff.evt.acqActive && !st_ff.evt.exposing;

    // exposure: trigger-width only with a line input as source
    widthMode = st_ff.expoWidth && st_ff.trgLine.mode && (st_ff.trgLine.src == `ETC_SRC_LINE);
    srcLevel = pickLine(st_ff.sync2, st_ff.trgLine.line) ^ st_ff.trgLine.fall;
    if (lineAccept) begin
      nxt_st.evt.lineStart = 1'b1;
      nxt_st.evt.exposing = 1'b1;
      nxt_st.expoCnt = st_ff.expoTime;
    end else if (st_ff.evt.exposing) begin
      if (widthMode) begin
        nxt_st.evt.exposing = srcLevel;
      end else if (st_ff.expoCnt <= 32'h1) begin
        nxt_st.evt.exposing = 1'b0;
        nxt_st.expoCnt = 32'h0;
      end else begin
        nxt_st.expoCnt = st_ff.expoCnt - 32'h1;
      end
    end

    // frame sequencing: idle, delay in lines, running a fixed line count
    case (st_ff.frameSt)
      FR_IDLE: begin
        if (st_ff.evt.acqActive) begin
          if (!st_ff.trgFrame.mode) begin
            startFrame = 1'b1;
          end else if (frameEdge) begin
            if (st_ff.frameDelay == 16'h0) begin
              startFrame = 1'b1;
            end else begin
              nxt_st.delayCnt = st_ff.frameDelay;
              nxt_st.frameSt = FR_DELAY;
            end
          end
        end
      end
      FR_DELAY: begin
        if (lineAccept) begin
          if (st_ff.delayCnt <= 16'h1) begin
            startFrame = 1'b1;
          end else begin
            nxt_st.delayCnt = st_ff.delayCnt - 16'h1;
          end
        end
      end
      FR_RUN: begin
        if (lineAccept) begin
          nxt_st.lineCnt = st_ff.lineCnt + 32'h1;
          if (st_ff.lineCnt + 32'h1 >= st_ff.frameLines) begin
            nxt_st.frameSt = FR_IDLE;
          end
        end
      end
      default: begin
        nxt_st.frameSt = FR_IDLE;
      end
    endcase
    if (startFrame) begin
      nxt_st.frameSt = FR_RUN;
      nxt_st.lineCnt = 32'h0;
      nxt_st.delayCnt = 16'h0;
      nxt_st.evt.frameStart = 1'b1;
    end
    nxt_st.evt.frameActive = (nxt_st.frameSt == FR_RUN);

    // apb: access answered one cycle after it opens, write lands at the ready edge
    if (apbReq.psel && apbReq.penable && !st_ff.rsp.pready) begin
      nxt_st.rsp.pready = 1'b1;
      nxt_st.rsp.pslverr = 1'b0;
      nxt_st.rsp.prdata = 32'h0;
      case (apbReq.paddr)
        `ETC_OFF_TRIG_ACQ: nxt_st.rsp.prdata = {26'h0, st_ff.trgAcq};
        `ETC_OFF_TRIG_FRAME: nxt_st.rsp.prdata = {26'h0, st_ff.trgFrame};
        `ETC_OFF_TRIG_LINE: nxt_st.rsp.prdata = {26'h0, st_ff.trgLine};
        `ETC_OFF_FRAME_DELAY: nxt_st.rsp.prdata = {16'h0, st_ff.frameDelay};
        `ETC_OFF_ENC_CFG: nxt_st.rsp.prdata = {26'h0, st_ff.encDirUp, st_ff.encHiRes,
                                                st_ff.encSrcB, st_ff.encSrcA};
        `ETC_OFF_ENC_DIV: nxt_st.rsp.prdata = st_ff.encDiv;
        `ETC_OFF_EXPO_CFG: nxt_st.rsp.prdata = {31'h0, st_ff.expoWidth};
        `ETC_OFF_EXPO_TIME: nxt_st.rsp.prdata = st_ff.expoTime;
        `ETC_OFF_LINE_PERIOD: nxt_st.rsp.prdata = st_ff.linePeriod;
        `ETC_OFF_FRAME_LINES: nxt_st.rsp.prdata = st_ff.frameLines;
        `ETC_OFF_SW_TRIG: nxt_st.rsp.prdata = 32'h0;
        `ETC_OFF_STATUS: nxt_st.rsp.prdata = {27'h0, (st_ff.frameSt == FR_DELAY), decDir,
                                               st_ff.evt.exposing, st_ff.evt.frameActive,
                                               st_ff.evt.acqActive};
        `ETC_OFF_ENC_POS: nxt_st.rsp.prdata = decPos;
        `ETC_OFF_LINE_COUNT: nxt_st.rsp.prdata = st_ff.lineCnt;
        default: nxt_st.rsp.pslverr = 1'b1;
      endcase
    end else if (st_ff.rsp.pready) begin
      nxt_st.rsp.pready = 1'b0;
      nxt_st.rsp.pslverr = 1'b0;
      if (apbReq.psel && apbReq.penable && apbReq.pwrite) begin
        case (apbReq.paddr)
          `ETC_OFF_TRIG_ACQ: nxt_st.trgAcq = etc_trig_cfg_t'(apbReq.pwdata[`ETC_TRG_FALL:0]);
          `ETC_OFF_TRIG_FRAME: nxt_st.trgFrame = etc_trig_cfg_t'(apbReq.pwdata[`ETC_TRG_FALL:0]);
          `ETC_OFF_TRIG_LINE: nxt_st.trgLine = etc_trig_cfg_t'(apbReq.pwdata[`ETC_TRG_FALL:0]);
          `ETC_OFF_FRAME_DELAY: nxt_st.frameDelay = apbReq.pwdata[15:0];
          `ETC_OFF_ENC_CFG: begin
            nxt_st.encSrcA = apbReq.pwdata[`ETC_ENC_SRCA_HI:`ETC_ENC_SRCA_LO];
            nxt_st.encSrcB = apbReq.pwdata[`ETC_ENC_SRCB_HI:`ETC_ENC_SRCB_LO];
            nxt_st.encHiRes = apbReq.pwdata[`ETC_ENC_HIRES];
            nxt_st.encDirUp = apbReq.pwdata[`ETC_ENC_DIRUP];
          end
          `ETC_OFF_ENC_DIV: begin
            nxt_st.encDiv = apbReq.pwdata;
            nxt_st.encAcc = 33'h0;
          end
          `ETC_OFF_EXPO_CFG: nxt_st.expoWidth = apbReq.pwdata[`ETC_EXPO_WIDTH];
          `ETC_OFF_EXPO_TIME: nxt_st.expoTime = apbReq.pwdata;
          `ETC_OFF_LINE_PERIOD: nxt_st.linePeriod = apbReq.pwdata;
          `ETC_OFF_FRAME_LINES: nxt_st.frameLines = apbReq.pwdata;
          `ETC_OFF_SW_TRIG: nxt_st.swPend = apbReq.pwdata[`ETC_SW_STOP:0];
          default: begin
            nxt_st.swPend = 4'h0;
          end
        endcase
      end
    end
  end

  // state register with documented reset values
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.encSrcA <= `ETC_RST_ENC_SRCA;
      st_ff.encSrcB <= `ETC_RST_ENC_SRCB;
      st_ff.encDiv <= `ETC_RST_ENC_DIV;
      st_ff.frameDelay <= `ETC_RST_FRAME_DELAY;
      st_ff.frameLines <= `ETC_RST_FRAME_LINES;
      st_ff.expoTime <= EXPO_RST_CYC;
      st_ff.linePeriod <= LINE_RST_CYC;
      st_ff.frameSt <= FR_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign apbRsp = st_ff.rsp;
  assign evt = st_ff.evt;
endmodule

// file: common/etc_params.svh
// offsets, field positions, reset values and timing counts of the encoder trigger block
// Notes on behaviour
// - acquisition, frame, line start each triggerable externally
// - line start from input line or divided encoder
// - full-cycle mode: one count per quadrature cycle, filtered
// - per-edge mode: count every phase transition, unfiltered
// - bidirectional output: pulses for both directions
// - forward-only output: reverse steps ignored
// - one output pulse per fractional step count
// - phase A and B each on any line
// - trigger mode on: event waits for source
// - trigger taken on configured activation edge
// - frame start delayed by configured line count
// - exposure timed or as wide as trigger
// - each accepted line trigger captures one line
// - triggered frame holds fixed line count
`ifndef ETC_PARAMS_SVH
`define ETC_PARAMS_SVH

`define ETC_OFF_TRIG_ACQ 8'h00
`define ETC_OFF_TRIG_FRAME 8'h04
`define ETC_OFF_TRIG_LINE 8'h08
`define ETC_OFF_FRAME_DELAY 8'h0c
`define ETC_OFF_ENC_CFG 8'h10
`define ETC_OFF_ENC_DIV 8'h14
`define ETC_OFF_EXPO_CFG 8'h18
`define ETC_OFF_EXPO_TIME 8'h1c
`define ETC_OFF_LINE_PERIOD 8'h20
`define ETC_OFF_FRAME_LINES 8'h24
`define ETC_OFF_SW_TRIG 8'h28
`define ETC_OFF_STATUS 8'h2c
`define ETC_OFF_ENC_POS 8'h30
`define ETC_OFF_LINE_COUNT 8'h34

`define ETC_TRG_MODE 0
`define ETC_TRG_SRC_LO 1
`define ETC_TRG_SRC_HI 2
`define ETC_TRG_LINE_LO 3
`define ETC_TRG_LINE_HI 4
`define ETC_TRG_FALL 5
`define ETC_SRC_ENC 2'h0
`define ETC_SRC_LINE 2'h1
`define ETC_SRC_SW 2'h2

`define ETC_ENC_SRCA_LO 0
`define ETC_ENC_SRCA_HI 1
`define ETC_ENC_SRCB_LO 2
`define ETC_ENC_SRCB_HI 3
`define ETC_ENC_HIRES 4
`define ETC_ENC_DIRUP 5
`define ETC_EXPO_WIDTH 0
`define ETC_SW_LINE 0
`define ETC_SW_FRAME 1
`define ETC_SW_ACQ 2
`define ETC_SW_STOP 3

`define ETC_RST_ENC_SRCA 2'h0
`define ETC_RST_ENC_SRCB 2'h1
`define ETC_RST_ENC_DIV 32'h00010000
`define ETC_RST_FRAME_DELAY 16'h0000
`define ETC_RST_FRAME_LINES 32'h00000400
`define ETC_ENC_ONE 33'h000010000

`define ETC_CLK_MHZ 250
`define ETC_EXPO_TIME_NS 21000
`define ETC_EXPO_CYC ((`ETC_EXPO_TIME_NS * `ETC_CLK_MHZ) / 1000)
`define ETC_LINE_PERIOD_NS 100000
`define ETC_LINE_PERIOD_CYC ((`ETC_LINE_PERIOD_NS * `ETC_CLK_MHZ) / 1000)

`endif

// file: common/etc_pkg.sv
// types shared by the encoder trigger block
package etc_pkg;

  typedef struct packed {
    logic fall;
    logic [1:0] line;
    logic [1:0] src;
    logic mode;
  } etc_trig_cfg_t;

  typedef enum logic [2:0] {
    FR_IDLE = 3'b001,
    FR_DELAY = 3'b010,
    FR_RUN = 3'b100
  } etc_frame_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } etc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } etc_apb_rsp_t;

  typedef struct packed {
    logic lineStart;
    logic frameStart;
    logic acqStart;
    logic exposing;
    logic frameActive;
    logic acqActive;
  } etc_evt_t;

  typedef struct packed {
    logic init;
    logic [1:0] prevAb;
    logic [2:0] sub;
    logic [31:0] pos;
    logic step;
    logic dir;
  } etc_dec_st_t;

endpackage

// file: rtl/etc_quad_decoder.sv
// quadrature decoder with full-cycle and per-edge counting
`timescale 1ns/1ps
module etc_quad_decoder (
  input wire logic mclk,
  input wire logic reset,
  input wire logic phaseA,
  input wire logic phaseB,
  input wire logic hiRes,
  output logic step,
  output logic dir,
  output logic [31:0] pos
);
  import etc_pkg::*;

  etc_dec_st_t st_ff;
  etc_dec_st_t nxt_st;

  // forward gray sequence 00 -> 01 -> 11 -> 10 -> 00
  function automatic logic [1:0] fwdNext(input logic [1:0] ab);
    case (ab)
      2'h0: fwdNext = 2'h1;
      2'h1: fwdNext = 2'h3;
      2'h3: fwdNext = 2'h2;
      default: fwdNext = 2'h0;
    endcase
  endfunction

  // step detection and counting
  always_comb begin
    logic [1:0] cur;
    logic up;
    logic dn;
    cur = {phaseA, phaseB};
    up = 1'b0;
    dn = 1'b0;
    nxt_st = st_ff;
    nxt_st.step = 1'b0;
    nxt_st.prevAb = cur;
    nxt_st.init = 1'b1;
    if (st_ff.init && (cur != st_ff.prevAb)) begin
      up = (cur == fwdNext(st_ff.prevAb));
      dn = (st_ff.prevAb == fwdNext(cur)); // double changes give neither
    end
    if (hiRes) begin
      nxt_st.sub = 3'h0;
      if (up || dn) begin
        nxt_st.step = 1'b1;
        nxt_st.dir = up;
        nxt_st.pos = up ? st_ff.pos + 32'h1 : st_ff.pos - 32'h1;
      end
    end else if (up) begin
      // back-and-forth jitter cancels inside the sub count
      if (st_ff.sub == 3'h3) begin
        nxt_st.sub = 3'h0;
        nxt_st.step = 1'b1;
        nxt_st.dir = 1'b1;
        nxt_st.pos = st_ff.pos + 32'h1;
      end else begin
        nxt_st.sub = st_ff.sub + 3'h1;
      end
    end else if (dn) begin
      if (st_ff.sub == 3'h5) begin
        nxt_st.sub = 3'h0;
        nxt_st.step = 1'b1;
        nxt_st.dir = 1'b0;
        nxt_st.pos = st_ff.pos - 32'h1;
      end else begin
        nxt_st.sub = st_ff.sub - 3'h1;
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign step = st_ff.step;
  assign dir = st_ff.dir;
  assign pos = st_ff.pos;
endmodule

// file: sim/etc_trigger_chk.sv
// concurrent checks on the ports of the encoder trigger top
`timescale 1ns/1ps
module etc_trigger_chk #(
  parameter logic [31:0] EXPO_RST_CYC = 32'h8,
  parameter logic [31:0] LINE_RST_CYC = 32'h14
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [2:0] lineIn,
  input etc_pkg::etc_apb_req_t apbReq,
  input etc_pkg::etc_apb_rsp_t apbRsp,
  input etc_pkg::etc_evt_t evt
);
  import etc_pkg::*;
  // one clock domain, checks idle during reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // line, frame, acquisition and exposure relations
  chk_line_single: assert property (evt.lineStart |=> !evt.lineStart)
    else $error("line start longer than one cycle");
  chk_line_expo: assert property (evt.lineStart |-> evt.exposing)
    else $error("line start without exposure");
  chk_expo_cause: assert property ($rose(evt.exposing) |-> evt.lineStart)
    else $error("exposure began without a line start");
  chk_line_gap: assert property (evt.lineStart |-> !$past(evt.exposing))
    else $error("line accepted during exposure");
  chk_acq_level: assert property (evt.acqStart |-> evt.acqActive)
    else $error("acquisition start without active level");
  chk_frame_acq: assert property (evt.frameStart |-> evt.acqActive)
    else $error("frame start outside acquisition");
  chk_frame_run: assert property (evt.frameStart |-> ##[0:1] evt.frameActive)
    else $error("frame start did not enter run");
  chk_frame_single: assert property (evt.frameStart |=> !evt.frameStart)
    else $error("frame start longer than one cycle");
  // bus answer timing and error answer form
  chk_ready_time: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready
      && !$past(apbReq.penable) |=> apbRsp.pready ##1 !apbRsp.pready)
    else $error("bus answer not one cycle after access");
  chk_err_data: assert property (apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 32'h0)
    else $error("error answer malformed");

  // main scenarios reached
  cover property (evt.frameStart);
  cover property (evt.lineStart && evt.frameActive);
  cover property (apbRsp.pslverr);
endmodule

bind etc_trigger_top etc_trigger_chk #(.EXPO_RST_CYC(EXPO_RST_CYC), .LINE_RST_CYC(LINE_RST_CYC))
  chkInst (.mclk(mclk), .reset(reset), .lineIn(lineIn), .apbReq(apbReq), .apbRsp(apbRsp),
  .evt(evt));

// file: sim/etc_enc_partner.sv
// quadrature encoder and trigger source model driving the three input lines
`timescale 1ns/1ps
module etc_enc_partner (
  input wire logic mclk,
  output logic [2:0] lineIn
);
  logic [2:0] pins = 3'h0; // a on line 0, b on line 1, barrier on line 2
  assign lineIn = pins;

  // both channels always wired, so either output setting is legal
  task automatic turn(input logic fwd, input int n);
    for (int i = 0; i < n; i++) begin
      pins[1:0] <= fwd ? {~pins[0], pins[1]} : {pins[0], ~pins[1]};
      repeat (4) @(posedge mclk);
    end
  endtask

  // level change on one line, held until the next call
  task automatic setPin(input int idx, input logic v);
    pins[idx] <= v;
    @(posedge mclk);
  endtask
endmodule

// file: sim/encoder_trigger_control_tb_top.sv
// self-checking bench for the encoder trigger block
`timescale 1ns/1ps
`include "etc_params.svh"
module encoder_trigger_control_tb_top;
  import etc_pkg::*;
  localparam logic [31:0] ExpoCyc = 32'h8;
  localparam logic [31:0] LineCyc = 32'h14;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] lineIn;
  etc_apb_req_t apbReq = '0;
  etc_apb_rsp_t apbRsp;
  etc_evt_t evt;
  int err_total = 0;
  int comparisons = 0;
  int lineCnt = 0;
  int frameCnt = 0;
  int acqCnt = 0;
  logic [31:0] q;
  logic e;
  logic [7:0] adr [9] = '{`ETC_OFF_TRIG_LINE, `ETC_OFF_FRAME_DELAY, `ETC_OFF_ENC_CFG,
    `ETC_OFF_ENC_DIV, `ETC_OFF_EXPO_CFG, `ETC_OFF_EXPO_TIME, `ETC_OFF_LINE_PERIOD,
    `ETC_OFF_FRAME_LINES, `ETC_OFF_SW_TRIG};
  logic [31:0] rstv [9] = '{32'h0, 32'h0, 32'h4, `ETC_RST_ENC_DIV, 32'h0, ExpoCyc, LineCyc,
    `ETC_RST_FRAME_LINES, 32'h0};

  etc_trigger_top #(.EXPO_RST_CYC(ExpoCyc), .LINE_RST_CYC(LineCyc)) DUT (.mclk(mclk),
    .reset(reset), .lineIn(lineIn), .apbReq(apbReq), .apbRsp(apbRsp), .evt(evt));
  etc_enc_partner encModel (.mclk(mclk), .lineIn(lineIn));

  // clock and event counters sampled mid-cycle
  always #2 mclk = ~mclk;
  always @(negedge mclk) begin
    if (evt.lineStart === 1'b1) lineCnt++;
    if (evt.frameStart === 1'b1) frameCnt++;
    if (evt.acqStart === 1'b1) acqCnt++;
  end

  task automatic close_out();
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    err_total++;
    $display("mismatch %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) bad(m);
  endtask
  task automatic ln_chk(input int l0, input int n, input string m);
    chk(32'(lineCnt - l0), 32'(n), m);
  endtask
  // a bounded wait that ran out counts a mismatch and ends the run
  task automatic lim(input int k, input int n, input string m);
    if (k >= n) begin
      bad(m);
      close_out();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one bus transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad("bus hang");
      close_out();
    end
    q = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic next_line(output int k);
    int c;
    c = lineCnt;
    k = 0;
    while (lineCnt == c && k < 200) begin
      @(posedge mclk);
      k++;
    end
    lim(k, 200, "line wait");
  endtask
  // encoder move with position and line count deltas
  task automatic enc_chk(input logic fwd, input int n, input int dPos, input int dLn);
    logic [31:0] p0;
    int l0;
    xfer(1'b0, `ETC_OFF_ENC_POS, 32'h0);
    p0 = q;
    l0 = lineCnt;
    encModel.turn(fwd, n);
    cyc(8);
    xfer(1'b0, `ETC_OFF_ENC_POS, 32'h0);
    chk(q - p0, 32'(dPos), "encoder position");
    ln_chk(l0, dLn, "encoder lines");
  endtask

  // hang guard
  initial begin
    cyc(100000);
    bad("timeout");
    close_out();
  end

  // main sequence
  initial begin
    int k;
    int l0;
    int f0;
    cyc(12);
    reset <= 1'b0;
    cyc(1);
    for (int i = 0; i < 9; i++) begin
      xfer(1'b0, adr[i], 32'h0);
      chk(q, rstv[i], "reset value");
    end
    xfer(1'b0, 8'h3c, 32'h0);
    chk({q[30:0], e}, 32'h1, "unmapped read");
    next_line(k);
    next_line(k);
    chk(32'(k), LineCyc, "free-run period");
    k = 0;
    @(negedge mclk);
    while (evt.exposing === 1'b1 && k < 100) begin
      k++;
      @(negedge mclk);
    end
    lim(k, 100, "exposure wait");
    chk(32'(k), ExpoCyc - 32'h1, "timed exposure");
    cyc(1);
    wr(`ETC_OFF_EXPO_CFG, 32'h1);
    wr(`ETC_OFF_TRIG_LINE, 32'h0b);
    cyc(20);
    l0 = lineCnt;
    cyc(60);
    ln_chk(l0, 0, "line waits for source");
    encModel.setPin(1, 1'b1);
    cyc(20);
    ln_chk(l0, 1, "rising line trigger");
    chk(32'(evt.exposing), 32'h1, "width exposure held");
    encModel.setPin(1, 1'b0);
    cyc(6);
    chk(32'(evt.exposing), 32'h0, "width exposure ended");
    wr(`ETC_OFF_EXPO_CFG, 32'h0);
    wr(`ETC_OFF_TRIG_LINE, 32'h2b);
    l0 = lineCnt;
    encModel.setPin(1, 1'b1);
    cyc(10);
    ln_chk(l0, 0, "rise ignored when falling active");
    encModel.setPin(1, 1'b0);
    cyc(6);
    ln_chk(l0, 1, "falling line trigger");
    wr(`ETC_OFF_EXPO_TIME, 32'h2);
    wr(`ETC_OFF_TRIG_LINE, 32'h1);
    enc_chk(1'b1, 16, 4, 4);
    enc_chk(1'b0, 8, -2, 2);
    wr(`ETC_OFF_ENC_CFG, 32'h24);
    enc_chk(1'b0, 8, -2, 0);
    enc_chk(1'b1, 8, 2, 2);
    wr(`ETC_OFF_ENC_CFG, 32'h4);
    enc_chk(1'b1, 2, 0, 0);
    enc_chk(1'b0, 2, 0, 0);
    wr(`ETC_OFF_ENC_CFG, 32'h14);
    enc_chk(1'b1, 6, 6, 6);
    wr(`ETC_OFF_ENC_CFG, 32'h11);
    enc_chk(1'b1, 8, -8, 8);
    wr(`ETC_OFF_ENC_CFG, 32'h14);
    wr(`ETC_OFF_ENC_DIV, 32'h00028000);
    enc_chk(1'b1, 10, 10, 4);
    wr(`ETC_OFF_TRIG_LINE, 32'h0);
    wr(`ETC_OFF_FRAME_LINES, 32'h3);
    cyc(100);
    wr(`ETC_OFF_FRAME_DELAY, 32'h2);
    wr(`ETC_OFF_TRIG_FRAME, 32'h13);
    cyc(100);
    f0 = frameCnt;
    cyc(100);
    chk(32'(frameCnt - f0), 32'h0, "frame waits for barrier");
    next_line(k); // align to a free-run line so no line falls between arming and l0
    encModel.setPin(2, 1'b1);
    cyc(4);
    l0 = lineCnt;
    k = 0;
    while (frameCnt == f0 && k < 400) begin
      @(posedge mclk);
      k++;
    end
    lim(k, 400, "frame start wait");
    ln_chk(l0, 2, "frame start delay");
    k = 0;
    @(negedge mclk);
    while (evt.frameActive === 1'b1 && k < 400) begin
      @(negedge mclk);
      k++;
    end
    lim(k, 400, "frame end wait");
    cyc(1);
    ln_chk(l0, 5, "fixed frame height");
    encModel.setPin(2, 1'b0);
    wr(`ETC_OFF_TRIG_LINE, 32'h05);
    cyc(30);
    l0 = lineCnt;
    wr(`ETC_OFF_SW_TRIG, 32'h1);
    cyc(6);
    ln_chk(l0, 1, "software line trigger");
    f0 = frameCnt;
    wr(`ETC_OFF_SW_TRIG, 32'h2);
    cyc(6);
    chk(32'(frameCnt - f0), 32'h0, "software frame ignored");
    wr(`ETC_OFF_TRIG_ACQ, 32'h05);
    wr(`ETC_OFF_SW_TRIG, 32'h8);
    cyc(4);
    xfer(1'b0, `ETC_OFF_STATUS, 32'h0);
    chk(32'(q[0]), 32'h0, "acquisition stopped");
    f0 = acqCnt;
    wr(`ETC_OFF_SW_TRIG, 32'h4);
    cyc(4);
    chk(32'(acqCnt - f0), 32'h1, "software acquisition start");
    xfer(1'b0, `ETC_OFF_STATUS, 32'h0);
    chk(32'(q[0]), 32'h1, "acquisition running");
    close_out();
  end
endmodule
